/* File: logic/tcg_clkgen.sv */
// clock generator: three pll models, output dividers and divider checking
//
// Functional notes
// - pll outputs count core_clk cycles, ref_clock_in only gates the lock wait; axi and static memory enables come from their own pins
// - each pll has two divided outputs
// - out_b rate is ref*(fb+1)/(ob+1)
// - out_c rate is ref*(fb+1)/(oc+1)
// - device drives mem_clock, up to 266 MHz once a request is accepted; the reset dividers give 266680 kHz
// - fast_fabric_clock never exceeds 200 MHz once a request is accepted; the reset dividers give 266680 kHz
// - core_clock never exceeds 400 MHz
// - external axi clock gets double-rate enable
// - static memory uses skewed feedback clock
`include "tcg_clk_map.svh"
`default_nettype none
module tcg_clkgen
	import tcg_pkg::*;
#(
	parameter int FB_W = `TCG_FB_W,
	parameter int OUT_W = `TCG_OUT_W,
	parameter int REF_KHZ = `TCG_REF_KHZ,
	parameter int LOCK_CYCLES = `TCG_LOCK_US * `TCG_CLK_MHZ
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// reference and external clocks, sampled as levels
	input wire logic ref_clock_in,
	input wire logic ext_axi_slave_clock,
	input wire logic smb_feedback_clock,
	// divider request, one value set per pll
	input wire logic cfg_load,
	input wire logic [`TCG_NUM_PLL*FB_W-1:0] cfg_feedback_divider,
	input wire logic [`TCG_NUM_PLL*OUT_W-1:0] cfg_out_b_divider,
	input wire logic [`TCG_NUM_PLL*OUT_W-1:0] cfg_out_c_divider,
	// status
	output logic cfg_error,
	output logic pll_locked,
	output logic [`TCG_NUM_PLL*FB_W-1:0] active_feedback_divider,
	// derived clock enables
	output logic [`TCG_NUM_PLL-1:0] pll_out_b,
	output logic [`TCG_NUM_PLL-1:0] pll_out_c,
	output logic core_clock,
	output logic fast_fabric_clock,
	output logic mem_clock,
	output logic mem_half_clock,
	output logic axi_double_rate,
	output logic static_mem_sample
);
	localparam int NP = `TCG_NUM_PLL;
	localparam int LW = $clog2(LOCK_CYCLES + 1);

	initial
	begin
		if (FB_W < 1 || OUT_W < 1 || LOCK_CYCLES < 1)
			$error("tcg_clkgen parameters out of range");
	end

	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	logic [2:0] s1_q, s2_q, s3_q;
	logic [2:0] s1_d, s2_d, s3_d;

	// pin levels pass three flops; stages two and three feed edge logic
	always_comb
	begin
		s1_d = {smb_feedback_clock, ext_axi_slave_clock, ref_clock_in};
		s2_d = s1_q;
		s3_d = s2_q;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	// one core_clk pulse per synced reference rise
	logic ref_edge;
	assign ref_edge = s2_q[0] & ~s3_q[0];

	// -------------------------------------------------------------
	// divider checking and loading
	// -------------------------------------------------------------
	logic [NP*FB_W-1:0] fb_q, fb_d;
	logic [NP*OUT_W-1:0] ob_q, ob_d, oc_q, oc_d;
	logic err_q, err_d;
	tcg_state_t st_q, st_d;
	logic [LW-1:0] lock_q, lock_d;
	logic ref_seen_q, ref_seen_d;
	logic [NP-1:0] ok_pll;
	logic [63:0] fkhz_b [NP];
	logic [63:0] fkhz_c [NP];

	// per pll limits; rates in kHz from the formulas
	for (genvar p = 0; p < NP; p++)
	begin : g_chk
		logic [63:0] m;
		logic [63:0] vco;
		assign m = 64'(cfg_feedback_divider[p*FB_W +: FB_W]) + 64'h1;
		assign vco = 64'h2 * 64'(REF_KHZ) * m;
		assign fkhz_b[p] = (64'(REF_KHZ) * m) /
			(64'(cfg_out_b_divider[p*OUT_W +: OUT_W]) + 64'h1);
		assign fkhz_c[p] = (64'(REF_KHZ) * m) /
			(64'(cfg_out_c_divider[p*OUT_W +: OUT_W]) + 64'h1);
		assign ok_pll[p] = (vco >= 64'(`TCG_VCO_MIN_KHZ))
			&& (vco <= 64'(`TCG_VCO_MAX_KHZ));
	end

	// pll0 b: core, pll1 b: fast fabric, pll2 b: memory, pll2 c: half memory
	logic ok_all;
	always_comb
	begin
		ok_all = &ok_pll;
		if (fkhz_b[0] > 64'(`TCG_CORE_MAX_KHZ))
			ok_all = 1'b0;
		if (fkhz_b[1] > 64'(`TCG_FAST_MAX_KHZ))
			ok_all = 1'b0;
		if (fkhz_b[2] > 64'(`TCG_MEM_MAX_KHZ))
			ok_all = 1'b0;
		// core to fast below five, kept on half steps via doubled rates
		if (64'h2 * fkhz_b[0] >= 64'(`TCG_RATIO_MAX_X2) * fkhz_b[1])
			ok_all = 1'b0;
		if (fkhz_b[0] < fkhz_b[1])
			ok_all = 1'b0;
		// half memory must be exactly mem over two
		if (64'(cfg_out_c_divider[2*OUT_W +: OUT_W]) + 64'h1 !=
			64'h2 * (64'(cfg_out_b_divider[2*OUT_W +: OUT_W]) + 64'h1))
			ok_all = 1'b0;
	end

	// load, then relock; a rejected request leaves the old values running
	always_comb
	begin
		st_d = st_q;
		fb_d = fb_q;
		ob_d = ob_q;
		oc_d = oc_q;
		err_d = err_q;
		lock_d = lock_q;
		ref_seen_d = ref_seen_q | ref_edge;
		case (st_q)
			TCG_IDLE:
			begin
				if (cfg_load)
					st_d = TCG_CHECK;
			end
			TCG_CHECK:
			begin
				if (ok_all)
				begin
					fb_d = cfg_feedback_divider;
					ob_d = cfg_out_b_divider;
					oc_d = cfg_out_c_divider;
					err_d = 1'b0;
					lock_d = '0;
					ref_seen_d = 1'b0;
					st_d = TCG_LOCKWAIT;
				end
				else
				begin
					err_d = 1'b1;
					st_d = TCG_IDLE;
				end
			end
			TCG_LOCKWAIT:
			begin
				// a dead reference keeps the lock wait open
				if (lock_q != LW'(LOCK_CYCLES))
					lock_d = lock_q + 1'b1;
				else if (ref_seen_q)
					st_d = TCG_IDLE;
			end
			default: st_d = TCG_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= TCG_LOCKWAIT;
			lock_q <= '0;
			ref_seen_q <= 1'b0;
			err_q <= 1'b0;
			fb_q <= {NP{FB_W'(`TCG_FB_RST)}};
			ob_q <= {NP{OUT_W'(`TCG_OB_RST)}};
			oc_q <= {NP{OUT_W'(`TCG_OC_RST)}};
		end
		else
		begin
			st_q <= st_d;
			lock_q <= lock_d;
			ref_seen_q <= ref_seen_d;
			err_q <= err_d;
			fb_q <= fb_d;
			ob_q <= ob_d;
			oc_q <= oc_d;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	logic run;
	assign run = (st_q != TCG_LOCKWAIT);

	// dividers count core_clk cycles, trading true rate for a pure enable pulse
	for (genvar p = 0; p < NP; p++)
	begin : g_pll
		tcg_div #(.WIDTH(OUT_W)) u_b (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.run(run),
			.div(ob_q[p*OUT_W +: OUT_W]),
			.tick(pll_out_b[p])
		);
		tcg_div #(.WIDTH(OUT_W)) u_c (
			.core_clk(core_clk),
			.rst_n(rst_n),
			.run(run),
			.div(oc_q[p*OUT_W +: OUT_W]),
			.tick(pll_out_c[p])
		);
	end

	// named clocks are the gated divider pulses
	assign core_clock = pll_out_b[0];
	assign fast_fabric_clock = pll_out_b[1];
	assign mem_clock = pll_out_b[2];
	assign mem_half_clock = pll_out_c[2];
	assign axi_double_rate = run & (s2_q[1] ^ s3_q[1]);
	assign static_mem_sample = run & s2_q[2] & ~s3_q[2];
	assign cfg_error = err_q;
	assign pll_locked = run;
	assign active_feedback_divider = fb_q;
endmodule
`default_nettype wire

/* File: logic/tcg_clk_map.svh */
// divider field widths, limits and reset values for the clock generator
`ifndef TCG_CLK_MAP_SVH
`define TCG_CLK_MAP_SVH
`define TCG_NUM_PLL 3
`define TCG_FB_W 7
`define TCG_OUT_W 5
`define TCG_REF_KHZ 66670
`define TCG_VCO_MIN_KHZ 650000
`define TCG_VCO_MAX_KHZ 1340000
`define TCG_FAST_MAX_KHZ 200000
`define TCG_CORE_MAX_KHZ 400000
`define TCG_MEM_MAX_KHZ 266000
`define TCG_RATIO_MAX_X2 10
`define TCG_LOCK_US 20
`define TCG_CLK_MHZ 125
`define TCG_FB_RST 7'h07
`define TCG_OB_RST 5'h01
`define TCG_OC_RST 5'h03
`endif

/* File: logic/tcg_pkg.sv */
// types shared by the clock generator files
`default_nettype none
package tcg_pkg;
	typedef enum logic [1:0] {TCG_IDLE, TCG_CHECK, TCG_LOCKWAIT} tcg_state_t;
endpackage
`default_nettype wire

/* File: logic/tcg_div.sv */
// one programmable output divider producing a one-cycle enable pulse
`include "tcg_clk_map.svh"
`default_nettype none
module tcg_div
	import tcg_pkg::*;
#(
	parameter int WIDTH = `TCG_OUT_W
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [WIDTH-1:0] div,
	// output enable pulse
	output logic tick
);
	initial
	begin
		if (WIDTH < 1)
			$error("tcg_div width too small");
	end

	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic tick_q, tick_d;

	// terminal count at div gives a period of div+1 cycles
	always_comb
	begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (!run)
			cnt_d = '0;
		else if (cnt_q >= div)
		begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
		else
			cnt_d = cnt_q + 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;
endmodule
`default_nettype wire

/* File: testbench/tcg_board_model.sv */
// board oscillators feeding the clock generator pins
`default_nettype none
module tcg_board_model (
	// clock pins toward the device
	output logic ref_clock_in,
	output logic ext_axi_slave_clock,
	output logic smb_feedback_clock
);
	timeunit 1ns;
	timeprecision 100ps;
	// free running, unrelated to core_clk so the synchronisers see every phase
	initial
	begin
		ref_clock_in = 1'b0;
		ext_axi_slave_clock = 1'b0;
		smb_feedback_clock = 1'b0;
	end
	always #7.5 ref_clock_in = ~ref_clock_in;
	always #16.7 ext_axi_slave_clock = ~ext_axi_slave_clock;
	always #10.0 smb_feedback_clock = ~smb_feedback_clock; // 50 MHz bus
endmodule
`default_nettype wire

/* File: testbench/tcg_clkgen_assertions.sv */
// port checker for the clock generator
`default_nettype none
module tcg_clkgen_chk #(
	parameter int LOCK_CYCLES = 4
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cfg_load,
	input wire logic cfg_error,
	input wire logic pll_locked,
	input wire logic [20:0] active_feedback_divider,
	input wire logic [2:0] pll_out_b,
	input wire logic [2:0] pll_out_c,
	input wire logic core_clock,
	input wire logic fast_fabric_clock,
	input wire logic mem_clock,
	input wire logic mem_half_clock,
	input wire logic axi_double_rate
);
	logic [15:0] lk_cnt_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// lock wait length, counted in helper logic to avoid long repetitions
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			lk_cnt_q <= 16'h0;
		else
			lk_cnt_q <= pll_locked ? 16'h0 : lk_cnt_q + 16'h1;
	a_core_map: assert property
		(core_clock == pll_out_b[0] && fast_fabric_clock == pll_out_b[1])
		else $error("core or fast clock not on its divider");
	a_mem_map: assert property
		(mem_clock == pll_out_b[2] && mem_half_clock == pll_out_c[2])
		else $error("memory clocks not on their dividers");
	// half memory pulses only ever land on a memory pulse
	a_half_mem: assert property (mem_half_clock |-> mem_clock)
		else $error("half memory clock not half of memory clock");
	// the lock wait only follows a request two cycles back
	a_lock_cause: assert property ($fell(pll_locked) |-> $past(cfg_load, 2))
		else $error("lock wait without a request");
	a_gate_lock: assert property
		(!pll_locked && !$past(pll_locked) |-> pll_out_b == 3'h0 && pll_out_c == 3'h0)
		else $error("divider pulse during lock wait");
	a_load_answer: assert property
		(cfg_load && pll_locked |-> ##2 (cfg_error ^ !pll_locked))
		else $error("request not answered two cycles later");
	a_reject_hold: assert property
		($rose(cfg_error) |-> pll_locked && $stable(active_feedback_divider))
		else $error("rejected request changed dividers");
	a_err_clear: assert property ($fell(cfg_error) |-> $fell(pll_locked))
		else $error("error cleared without an accepted request");
	a_lock_len: assert property
		($rose(pll_locked) |-> lk_cnt_q >= LOCK_CYCLES + 1 && lk_cnt_q <= LOCK_CYCLES + 2)
		else $error("lock wait has wrong length");
	a_mem_gap: assert property (mem_clock |=> !mem_clock)
		else $error("memory clock faster than allowed");
	c_reject: cover property ($rose(cfg_error));
	c_accept: cover property ($fell(pll_locked));
	c_axi: cover property (axi_double_rate);
endmodule
bind tcg_clkgen tcg_clkgen_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (.core_clk, .rst_n, .cfg_load,
	.cfg_error, .pll_locked, .active_feedback_divider, .pll_out_b, .pll_out_c, .core_clock,
	.fast_fabric_clock, .mem_clock, .mem_half_clock, .axi_double_rate);
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the clock generator
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_load = 1'b0;
	logic [20:0] fb = 21'h0;
	logic [14:0] ob = 15'h0;
	logic [14:0] oc = 15'h0;
	logic rc, ac, sc, cfg_error, pll_locked, cck, fck, mck, hck, adr, sms;
	logic [20:0] act;
	logic [2:0] pb, pc;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	// vco low, vco high, core, fast, mem too fast, core below fast, ratio, half mem
	logic [6:0] rj_fb [8] = '{7'h03, 7'h0a, 7'h08, 7'h08, 7'h08, 7'h08, 7'h08, 7'h08};
	logic [14:0] rj_ob [8] = '{15'h0861, 15'h0861, 15'h0860, 15'h0821, 15'h0461, 15'h0864,
		15'h0921, 15'h0861};
	logic [4:0] rj_oc [8] = '{5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h05, 5'h04};
	always #4 core_clk = ~core_clk;
	tcg_board_model brd_u (.ref_clock_in(rc), .ext_axi_slave_clock(ac), .smb_feedback_clock(sc));
	tcg_clkgen #(.LOCK_CYCLES(4)) dut_u (.core_clk, .rst_n, .ref_clock_in(rc),
		.ext_axi_slave_clock(ac), .smb_feedback_clock(sc), .cfg_load, .cfg_feedback_divider(fb),
		.cfg_out_b_divider(ob), .cfg_out_c_divider(oc), .cfg_error, .pll_locked,
		.active_feedback_divider(act), .pll_out_b(pb), .pll_out_c(pc), .core_clock(cck),
		.fast_fabric_clock(fck), .mem_clock(mck), .mem_half_clock(hck), .axi_double_rate(adr),
		.static_mem_sample(sms));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one request; returns just after the edge following the one that carries the answer
	task automatic req(input logic [6:0] f, input logic [14:0] b, input logic [4:0] c2);
		@(posedge core_clk);
		fb <= {3{f}};
		ob <= b;
		oc <= {c2, 10'h063};
		cfg_load <= 1'b1;
		@(posedge core_clk);
		cfg_load <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task automatic wait_lock();
		repeat (50) if (!pll_locked) @(posedge core_clk);
		#1;
		check(pll_locked, 1'b1);
	endtask
	// pulses of {pll_out_c, pll_out_b}[k] over 60 cycles
	task automatic count(input int k, input int exp);
		int n;
		logic [5:0] v;
		n = 0;
		repeat (60)
		begin
			@(negedge core_clk);
			v = {pc, pb};
			n += v[k];
		end
		check(n, exp);
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		int na;
		int ns;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		wait_lock();
		count(0, 30);
		count(3, 15);
		$display("test reset dividers done");
		// mem at 200 MHz: memory controller settings are the board side's job
		req(7'h08, 15'h0861, 5'h05);
		check({cfg_error, pll_locked, act}, {2'b00, {3{7'h08}}});
		wait_lock();
		count(1, 15);
		count(2, 20);
		count(5, 10);
		$display("test accepted dividers done");
		for (int i = 0; i < 8; i++)
		begin
			req(rj_fb[i], rj_ob[i], rj_oc[i]);
			check({cfg_error, pll_locked, act}, {2'b11, {3{7'h08}}});
		end
		$display("test rejected dividers done");
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		check({cfg_error, act}, {1'b0, {3{7'h07}}});
		wait_lock();
		req(7'h08, 15'h0901, 5'h05);
		check({cfg_error, pll_locked}, 2'b00);
		wait_lock();
		$display("test reset and half step ratio done");
		na = 0;
		ns = 0;
		repeat (400)
		begin
			@(negedge core_clk);
			na += adr;
			ns += sms;
		end
		check(na >= 190 && na <= 193, 1'b1);
		check(ns >= 159 && ns <= 161, 1'b1);
		$display("test external clocks done");
		give_verdict();
	end
endmodule
`default_nettype wire
